//--- src/opa_arbiter.sv
// Three-stage arbiter picking one request per hi-res period
`timescale 1ns/10ps
module opa_arbiter (
	// Events and selections
	input wire opa_pkg::opa_events_t events,
	input wire logic [31:0] set_sel,
	input wire logic [31:0] rst_sel,
	input wire logic counter_en,
	// Winning request
	output logic req_valid,
	output opa_pkg::opa_kind_t req_kind,
	output logic [opa_pkg::DLY_W-1:0] req_pos
);
	// Highest set bit wins, used for every class
	function automatic logic [4:0] hi_index(input logic [31:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = 0; i < 32; i++)
			if (v[i])
				idx = 5'(i);
		return idx;
	endfunction
	localparam logic [31:0] CLS_MASK [opa_pkg::CLS_N] =
		'{opa_pkg::CLS_OWN, opa_pkg::CLS_MST, opa_pkg::CLS_IC, opa_pkg::CLS_LP};
	// Software event passes regardless of counter enable
	wire logic [31:0] gate = counter_en ? 32'hFFFF_FFFF : (32'h0000_0001 << opa_pkg::EV_SW);
	wire logic [31:0] live = events.fire & (set_sel | rst_sel) & gate;
	logic [opa_pkg::CLS_N-1:0] cls_v;
	logic [opa_pkg::CLS_N-1:0][opa_pkg::DLY_W-1:0] cls_dly;
	opa_pkg::opa_kind_t cls_kind [opa_pkg::CLS_N];
	// First stage: one winner per class by index
	for (genvar c = 0; c < opa_pkg::CLS_N; c++)
	begin : g_cls
		wire logic [31:0] m = live & CLS_MASK[c];
		wire logic [4:0] w = hi_index(m);
		assign cls_v[c] = |m;
		assign cls_dly[c] = events.delay[w];
		// Both selections means toggle
		assign cls_kind[c] = (set_sel[w] & rst_sel[w]) ? opa_pkg::REQ_TOG :
			rst_sel[w] ? opa_pkg::REQ_RST : opa_pkg::REQ_SET;
	end
	// Second stage earliest delay, third stage kind priority
	always_comb
	begin
		logic [opa_pkg::DLY_W-1:0] best;
		best = '1;
		for (int c = 0; c < opa_pkg::CLS_N; c++)
			if (cls_v[c] && cls_dly[c] < best)
				best = cls_dly[c];
		req_kind = opa_pkg::REQ_NONE;
		for (int c = 0; c < opa_pkg::CLS_N; c++)
			if (cls_v[c] && cls_dly[c] == best)
			begin
				if (cls_kind[c] == opa_pkg::REQ_RST)
					req_kind = opa_pkg::REQ_RST;
				else if (cls_kind[c] == opa_pkg::REQ_TOG && req_kind != opa_pkg::REQ_RST)
					req_kind = opa_pkg::REQ_TOG;
				else if (req_kind == opa_pkg::REQ_NONE)
					req_kind = cls_kind[c];
			end
		req_valid = |cls_v;
		req_pos = best;
	end
endmodule

//--- src/opa_narrow_pipe.sv
// Three-stage edge pipeline that coarsens narrow pulses
`timescale 1ns/10ps
module opa_narrow_pipe (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Incoming edge
	input wire opa_pkg::opa_edge_t edge_in,
	// Shaped output-prepare level and edge position
	output logic level_q,
	output logic [opa_pkg::DLY_W-1:0] pos_q
);
	opa_pkg::opa_edge_t s1_q, s2_q;
	// Any edge still in flight means this one closes a narrow pulse
	wire logic narrow = edge_in.change & (s1_q.change | s2_q.change);
	// Stage registers; coarsened edges land on period boundaries
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			level_q <= 1'b0;
			pos_q <= '0;
		end
		else
		begin
			s1_q <= edge_in;
			if (narrow)
				s1_q.pos <= '0;
			s2_q <= s1_q;
			if (narrow)
				s2_q.pos <= '0;
			if (s2_q.change)
			begin
				level_q <= s2_q.level;
				// A partner edge arriving now closes a narrow pulse; coarsen this one too
				pos_q <= narrow ? '0 : s2_q.pos;
			end
		end
	end
endmodule

//--- src/opa_pkg.sv
// Constants, field layouts and carrier types for the output-prepare arbiter
package opa_pkg;
	// Event vector geometry
	localparam int EV_N = 32;
	localparam int DLY_W = 3;
	localparam int EV_SW = 0;
	// Class membership masks over the 32 selectable events
	localparam logic [31:0] CLS_OWN = 32'h0000_007C;
	localparam logic [31:0] CLS_MST = 32'h0000_0F80;
	localparam logic [31:0] CLS_IC = 32'h001F_F000;
	localparam logic [31:0] CLS_LP = 32'hFFE0_0003;
	localparam int CLS_N = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SET0 = 8'h04;
	localparam logic [7:0] OFS_RST0 = 8'h08;
	localparam logic [7:0] OFS_SET1 = 8'h0C;
	localparam logic [7:0] OFS_RST1 = 8'h10;
	localparam logic [7:0] OFS_INTEN = 8'h14;
	localparam logic [7:0] OFS_FLAG = 8'h18;
	localparam logic [7:0] OFS_FLAGCLR = 8'h1C;
	// Control field positions
	localparam int CTRL_DIV_LSB = 0;
	localparam int CTRL_DTE = 4;
	localparam int CTRL_BME = 5;
	localparam int CTRL_SCE = 6;
	localparam logic [6:0] CTRL_RST = 7'h00;
	// Enable register: interrupt enables low nibble, DMA enables at this offset
	localparam int INTEN_DMA_LSB = 8;
	// Flag register: output-prepare levels at this offset
	localparam int FLAG_LVL_LSB = 8;
	// Divider thresholds selecting the narrow pulse policy
	localparam logic [3:0] DIV_CASE1_MIN = 4'b0101;
	localparam logic [3:0] DIV_CASE0_EXTRA = 4'b1000;
	localparam logic [3:0] DIV_PSC_BASE = 4'b0100;
	// Two changes this many periods apart or less count as narrow
	localparam logic [1:0] NARROW_GAP = 2'h2;
	// Request kinds, one-hot
	typedef enum logic [3:0] {
		REQ_NONE = 4'b0001,
		REQ_SET = 4'b0010,
		REQ_TOG = 4'b0100,
		REQ_RST = 4'b1000
	} opa_kind_t;
	// Events arriving in one hi-res period with their sub-period delays
	typedef struct packed {
		logic [EV_N-1:0] fire;
		logic [EV_N-1:0][DLY_W-1:0] delay;
	} opa_events_t;
	// One edge of an output-prepare signal
	typedef struct packed {
		logic change;
		logic level;
		logic [DLY_W-1:0] pos;
	} opa_edge_t;
endpackage

//--- src/opa_top.sv
// Output-prepare arbitration, narrow pulse shaping and regular crossbar
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module opa_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer events and state
	input wire opa_pkg::opa_events_t events,
	input wire logic timer_run_or_idle,
	// Crossbar outputs with sub-period edge position
	output logic chan0_crossbar_out,
	output logic chan1_crossbar_out,
	output logic [opa_pkg::DLY_W-1:0] chan0_edge_pos,
	output logic [opa_pkg::DLY_W-1:0] chan1_edge_pos,
	// Flag requests: bit0 ch0 active, bit1 ch0 inactive, bit2 ch1 active, bit3 ch1 inactive
	output logic [3:0] edge_irq,
	output logic [3:0] edge_dma
);
	// Register storage
	logic [6:0] ctrl_q;
	logic [31:0] set_sel_q [2];
	logic [31:0] rst_sel_q [2];
	// Enables and flags use the edge request bit order
	logic [3:0] int_en_q;
	logic [3:0] dma_en_q;
	logic [3:0] flag_q;
	logic [3:0] flag_d;
	// APB answer registers
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	// Crossbar and request registers
	logic [1:0] xbar_q;
	logic [1:0] xbar_d;
	logic [1:0][opa_pkg::DLY_W-1:0] xpos_q;
	logic [3:0] irq_q;
	logic [3:0] dma_q;
	// Prescaler counter
	logic [3:0] psc_cnt_q;

	// Control fields
	wire logic [3:0] counter_clock_divider = ctrl_q[opa_pkg::CTRL_DIV_LSB +: 4];
	wire logic dead_time_enable = ctrl_q[opa_pkg::CTRL_DTE];
	wire logic balanced_mode_enable = ctrl_q[opa_pkg::CTRL_BME];
	wire logic slave_counter_enable = ctrl_q[opa_pkg::CTRL_SCE];

	// Policy selection from the divider
	wire logic policy_one = (counter_clock_divider >= opa_pkg::DIV_CASE1_MIN) &
		~counter_clock_divider[3];
	// Divider codes of eight and above also fall back to the first policy
	wire logic policy_zero = ~policy_one;
	// Prescaled clock active edge; ratio doubles per divider step past the base
	// Only the two low bits of the shift matter: ratios of two, four and eight
	wire logic [3:0] psc_shift = counter_clock_divider - opa_pkg::DIV_PSC_BASE;
	wire logic [3:0] psc_mask = 4'((5'h01 << psc_shift[1:0]) - 5'h01);
	wire logic psc_tick = (psc_cnt_q & psc_mask) == psc_mask;

	// Regular mode only when neither other mode is on
	wire logic regular_mode = ~dead_time_enable & ~balanced_mode_enable;

	// Events seen by both arbiters; the second policy coarsens every edge to a
	// prescaled tick, so sub-period delay must not decide between set and reset
	opa_pkg::opa_events_t arb_events;
	// Pulses pass unchanged
	assign arb_events.fire = events.fire;
	// Equal delays leave the kind priority in charge, so a coincident reset wins
	assign arb_events.delay = policy_one ? '0 : events.delay;

	// APB decode
	wire logic apb_access = psel & penable;
	wire logic apb_done = apb_access & pready_q;
	wire logic apb_wr = apb_done & pwrite;
	// Full byte address compare; any other offset answers with an error
	wire logic hit_ctrl = paddr == opa_pkg::OFS_CTRL;
	wire logic hit_set0 = paddr == opa_pkg::OFS_SET0;
	wire logic hit_rst0 = paddr == opa_pkg::OFS_RST0;
	wire logic hit_set1 = paddr == opa_pkg::OFS_SET1;
	wire logic hit_rst1 = paddr == opa_pkg::OFS_RST1;
	wire logic hit_inten = paddr == opa_pkg::OFS_INTEN;
	wire logic hit_flag = paddr == opa_pkg::OFS_FLAG;
	wire logic hit_clr = paddr == opa_pkg::OFS_FLAGCLR;
	wire logic hit_any = hit_ctrl | hit_set0 | hit_rst0 | hit_set1 | hit_rst1 |
		hit_inten | hit_flag | hit_clr;
	// Flag register is read only, clear register write only
	wire logic bad_access = ~hit_any | (pwrite & hit_flag) | (~pwrite & hit_clr);

	// Output-prepare levels per channel
	logic [1:0] output_prepare;
	wire logic output_prepare_zero = output_prepare[0];
	wire logic output_prepare_one = output_prepare[1];
	logic [1:0][opa_pkg::DLY_W-1:0] prep_pos;

	// Read data mux
	// The write-only clear register and unknown offsets read as zero
	wire logic [31:0] rd_mux =
		hit_ctrl ? {25'h000_0000, ctrl_q} :
		hit_set0 ? set_sel_q[0] :
		hit_rst0 ? rst_sel_q[0] :
		hit_set1 ? set_sel_q[1] :
		hit_rst1 ? rst_sel_q[1] :
		hit_inten ? {20'h0_0000, dma_en_q, 4'h0, int_en_q} :
		hit_flag ? {22'h00_0000, output_prepare_one, output_prepare_zero, 4'h0, flag_q} :
		32'h0000_0000;

	// APB answer: one wait state, data and error from flops
	// Every access gets exactly one wait state, so pready, prdata and pslverr
	// all come straight from flops; read data show the registers one cycle
	// before the completing edge, which software never notices
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Bus quiet, no answer pending
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (apb_access && !pready_q)
		begin
			// First access cycle: latch the answer for the next edge
			pready_q <= 1'b1;
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= bad_access;
		end
		else
		begin
			// Answer stands one cycle only; prdata keeps its last value
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Control and enable registers, written at the completing edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Everything off: first policy, regular mode, counter stopped
			ctrl_q <= opa_pkg::CTRL_RST;
			int_en_q <= 4'h0;
			dma_en_q <= 4'h0;
		end
		else if (apb_wr)
		begin
			// Only the seven control bits are kept
			if (hit_ctrl)
				ctrl_q <= pwdata[6:0];
			// Interrupt enables low, DMA enables from their own offset
			if (hit_inten)
			begin
				int_en_q <= pwdata[3:0];
				dma_en_q <= pwdata[opa_pkg::INTEN_DMA_LSB +: 4];
			end
		end
	end

	// Free-running prescaler for the second policy
	// It never stops, so the tick phase is fixed from reset; a divider change
	// only alters how many low bits must be all ones before a tick
	// Requests held across a divider change fire at the new ratio; a change to a first-policy code drops them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			psc_cnt_q <= 4'h0;
		else
			psc_cnt_q <= psc_cnt_q + 4'h1;
	end

	// Per-channel set/reset path; channel one mirrors channel zero
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		// Winning request of this period
		logic req_valid;
		opa_pkg::opa_kind_t req_kind;
		logic [opa_pkg::DLY_W-1:0] req_pos;
		// Committed level
		logic level_q;
		// Second-policy request waiting for its tick
		logic pend_q;
		logic pend_level_q;
		// Edge handed to the shaping pipe
		opa_pkg::opa_edge_t edge_in;

		// Selection registers
		// A new selection applies from the period after the write
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				set_sel_q[c] <= 32'h0000_0000;
				rst_sel_q[c] <= 32'h0000_0000;
			end
			else if (apb_wr)
			begin
				if (c == 0 ? hit_set0 : hit_set1)
					set_sel_q[c] <= pwdata;
				if (c == 0 ? hit_rst0 : hit_rst1)
					rst_sel_q[c] <= pwdata;
			end
		end

		// Arbitration of this period's events
		opa_arbiter u_arb (
			.events(arb_events),
			.set_sel(set_sel_q[c]),
			.rst_sel(rst_sel_q[c]),
			.counter_en(slave_counter_enable),
			.req_valid(req_valid),
			.req_kind(req_kind),
			.req_pos(req_pos)
		);

		// Target level for this request; the base is the latest pending value
		// A toggle flips what the output will be once any held request settles
		wire logic base_level = (policy_one & pend_q) ? pend_level_q : level_q;
		wire logic req_level = (req_kind == opa_pkg::REQ_SET) ? 1'b1 :
			(req_kind == opa_pkg::REQ_RST) ? 1'b0 : ~base_level;

		// Second policy: a request this cycle overrides any pending one
		wire logic p1_has = req_valid | pend_q;
		wire logic p1_level = req_valid ? req_level : pend_level_q;
		wire logic p1_fire = psc_tick & p1_has;

		// Edge presented to the shaping pipe
		always_comb
		begin
			edge_in = '0;
			if (policy_zero)
			begin
				// First policy: act at once at the arbitrated position
				edge_in.change = req_valid & (req_level != level_q);
				edge_in.level = req_level;
				edge_in.pos = req_pos;
			end
			else
			begin
				// Second policy: edges wait for the tick, position zero
				edge_in.change = p1_fire & (p1_level != level_q);
				edge_in.level = p1_level;
			end
		end

		// Committed level and pending request
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				level_q <= 1'b0;
				pend_q <= 1'b0;
				pend_level_q <= 1'b0;
			end
			else
			begin
				// Track the level the pipe will show, so no-op requests make no edge
				if (edge_in.change)
					level_q <= edge_in.level;
				// The first policy never holds; the second drops its hold at the tick
				if (policy_zero || p1_fire)
					pend_q <= 1'b0;
				else if (req_valid)
				begin
					pend_q <= 1'b1;
					// A newer request replaces the held one
					pend_level_q <= req_level;
				end
			end
		end

		// Narrow pulse shaping and output timing
		// Every edge spends three periods here, so the output lags the
		// request by a fixed latency in the first policy; the second adds the wait for the tick
		opa_narrow_pipe u_pipe (
			.pclk(pclk),
			.presetn(presetn),
			.edge_in(edge_in),
			.level_q(output_prepare[c]),
			.pos_q(prep_pos[c])
		);

		// Regular crossbar: each channel follows its own prepare signal
		// Outside regular mode the crossbar shows the inactive level
		assign xbar_d[c] = regular_mode ? output_prepare[c] : 1'b0;
	end

	// Edge detection on the crossbar outputs while running or idle
	// Flags follow the crossbar, not the prepare signal, so leaving regular
	// mode while high counts as a falling edge
	wire logic [1:0] rise = xbar_d & ~xbar_q & {2{timer_run_or_idle}};
	wire logic [1:0] fall = ~xbar_d & xbar_q & {2{timer_run_or_idle}};
	wire logic [3:0] flag_set = {fall[1], rise[1], fall[0], rise[0]};
	wire logic [3:0] flag_clr = (apb_wr & hit_clr) ? pwdata[3:0] : 4'h0;

	// New flag value: a set in the clearing cycle wins
	// so software never loses an edge that lands on its own clear
	always_comb
	begin
		flag_d = (flag_q & ~flag_clr) | flag_set;
	end

	// Crossbar outputs, flags and request lines
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Quiet outputs until the first arbitrated request
			xbar_q <= 2'h0;
			xpos_q <= '0;
			flag_q <= 4'h0;
			irq_q <= 4'h0;
			dma_q <= 4'h0;
		end
		else
		begin
			xbar_q <= xbar_d;
			xpos_q <= prep_pos;
			flag_q <= flag_d;
			// Requests are flags gated by enables, so a clear drops them too
			irq_q <= flag_d & int_en_q;
			dma_q <= flag_d & dma_en_q;
		end
	end

	// Output drive
	// Every output is a flop; nothing combinational reaches a pin
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign chan0_crossbar_out = xbar_q[0];
	assign chan1_crossbar_out = xbar_q[1];
	assign chan0_edge_pos = xpos_q[0];
	assign chan1_edge_pos = xpos_q[1];
	assign edge_irq = irq_q;
	assign edge_dma = dma_q;
endmodule

//--- test/opa_stage_model.sv
// Downstream stage model that measures crossbar pulse widths
`timescale 1ns/10ps
module opa_stage_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Crossbar level from the block
	input wire logic xbar_in,
	// Width in cycles of the last completed high pulse
	output logic [7:0] width_q
);
	logic [7:0] run_q; // Cycles high so far
	// Count high cycles and keep the count when the level drops
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			run_q <= 8'h00;
			width_q <= 8'h00;
		end
		else if (xbar_in)
			run_q <= run_q + 8'h01;
		else
		begin
			width_q <= (run_q != 8'h00) ? run_q : width_q;
			run_q <= 8'h00;
		end
endmodule

//--- test/opa_top_props.sv
// Port-level assertions for the output-prepare block
`timescale 1ns/10ps
module opa_top_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Timer state and outputs
	input wire logic timer_run_or_idle,
	input wire logic chan0_crossbar_out,
	input wire logic chan1_crossbar_out,
	input wire logic [opa_pkg::DLY_W-1:0] chan0_edge_pos,
	input wire logic [3:0] edge_irq,
	input wire logic [3:0] edge_dma
);
	logic wr_done; // Completed APB write
	logic [31:0] inten_q; // Shadow of the enable register
	logic [1:0] mode_q; // Shadow of the two mode enables
	assign wr_done = psel && penable && pready && pwrite;
	// Track enables and crossbar mode as software writes them
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			inten_q <= 32'h0000_0000;
			mode_q <= 2'b00;
		end
		else if (wr_done && paddr == opa_pkg::OFS_INTEN)
			inten_q <= pwdata;
		else if (wr_done && paddr == opa_pkg::OFS_CTRL)
			mode_q <= pwdata[5:4];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_edge0;
		$changed(chan0_crossbar_out);
	endsequence
	sequence s_rise0;
		$rose(chan0_crossbar_out) && inten_q[0];
	endsequence
	a_reset_quiet:
		assert property ($rose(presetn) |-> !chan0_crossbar_out && !chan1_crossbar_out && edge_irq == 4'h0)
		else $error("outputs not quiet after reset");
	a_narrow_pos:
		assert property (s_edge0 ##[1:2] s_edge0 |-> chan0_edge_pos == 3'h0)
		else $error("narrow pulse edge not coarsened");
	a_active_irq:
		assert property (s_rise0 and timer_run_or_idle |-> ##[0:1] edge_irq[0])
		else $error("active edge request missing");
	a_idle_gate:
		assert property (s_rise0 and !timer_run_or_idle && !edge_irq[0] |=> !edge_irq[0])
		else $error("flag set while timer stopped");
	a_inactive_dma:
		assert property ($fell(chan0_crossbar_out) && timer_run_or_idle && inten_q[9]
			|-> ##[0:1] edge_dma[1])
		else $error("inactive edge request missing");
	a_chan1_irq:
		assert property ($rose(chan1_crossbar_out) && timer_run_or_idle && inten_q[2]
			|-> ##[0:1] edge_irq[2])
		else $error("channel one active request missing");
	a_clear_flag:
		assert property (wr_done && paddr == opa_pkg::OFS_FLAGCLR && pwdata[0]
			&& $stable(chan0_crossbar_out) |-> ##2 !edge_irq[0])
		else $error("flag clear ignored");
	a_regular_low:
		assert property ((mode_q != 2'b00) [*3] |-> !chan0_crossbar_out && !chan1_crossbar_out)
		else $error("crossbar active outside regular mode");
endmodule
bind opa_top opa_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .timer_run_or_idle, .chan0_crossbar_out, .chan1_crossbar_out,
	.chan0_edge_pos, .edge_irq, .edge_dma);

//--- test/tb_top.sv
// Self-checking bench for the output-prepare block
`timescale 1ns/10ps
module tb_top;
	logic pclk = 1'b0; // Hi-res and bus clock
	logic presetn = 1'b0; // Active low reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
	logic pready, pslverr, errv, ch0, ch1;
	logic run = 1'b1; // Timer in run or idle state
	opa_pkg::opa_events_t ev = '0; // Event pulses and delays
	logic [2:0] pos0, pos1;
	logic [3:0] irq, dma;
	logic [7:0] width0; // Last pulse width seen downstream
	logic prev0 = 1'b0;
	int mismatches = 0, checks_done = 0, cyc = 0, edge_cyc = 0;
	always #12.5 pclk = ~pclk;
	opa_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .events(ev), .timer_run_or_idle(run), .chan0_crossbar_out(ch0),
		.chan1_crossbar_out(ch1), .chan0_edge_pos(pos0), .chan1_edge_pos(pos1),
		.edge_irq(irq), .edge_dma(dma));
	opa_stage_model far (.pclk, .presetn, .xbar_in(ch0), .width_q(width0));
	// Cycle of the latest channel 0 change
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		prev0 <= ch0;
		if (prev0 !== ch0)
			edge_cyc <= cyc;
	end
	task automatic summarize();
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; holds everything until pready is sampled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk) n++;
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			mismatches++;
			summarize();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Fire event set a, then set b after gap cycles, then let outputs settle
	task automatic fire(input logic [31:0] a, input logic [31:0] b, input int gap);
		ev.fire <= a;
		@(posedge pclk);
		ev.fire <= (gap == 1) ? b : 32'h0000_0000;
		@(posedge pclk);
		ev.fire <= (gap == 2) ? b : 32'h0000_0000;
		@(posedge pclk);
		ev.fire <= 32'h0000_0000;
		repeat (12) @(posedge pclk);
	endtask
	task automatic t_reset();
		chk("xbar", 32'h0000_0000, {ch1, ch0, irq, dma});
		apb(1'b0, opa_pkg::OFS_FLAG, 32'h0000_0000);
		chk("flags", 32'h0000_0000, rdv[9:0]);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, errv);
	endtask
	task automatic t_basic();
		apb(1'b1, opa_pkg::OFS_SET0, 32'h0000_0009);
		apb(1'b1, opa_pkg::OFS_RST0, 32'h0000_0010);
		fire(32'h0000_0008, 32'h0000_0000, 0);
		chk("gated", 32'h0000_0000, ch0);
		fire(32'h0000_0001, 32'h0000_0000, 0);
		chk("soft set", 32'h0000_0001, {ch1, ch0});
		apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0040);
		fire(32'h0000_0010, 32'h0000_0000, 0);
		chk("reset", 32'h0000_0000, ch0);
	endtask
	task automatic t_arbit();
		apb(1'b1, opa_pkg::OFS_SET0, 32'h0000_0144);
		apb(1'b1, opa_pkg::OFS_RST0, 32'h0000_021C);
		fire(32'h0000_0048, 32'h0000_0000, 0);
		chk("cmp3 over cmp0", 32'h0000_0001, ch0);
		fire(32'h0000_0104, 32'h0000_0000, 0);
		chk("toggle over set", 32'h0000_0000, ch0);
		fire(32'h0000_0204, 32'h0000_0000, 0);
		chk("reset over toggle", 32'h0000_0000, ch0);
		ev.delay[8] <= 3'h1;
		ev.delay[4] <= 3'h5;
		fire(32'h0000_0110, 32'h0000_0000, 0);
		chk("earliest wins", 32'h0000_0001, ch0);
		chk("edge pos", 32'h0000_0001, pos0);
	endtask
	task automatic t_mode();
		apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0050);
		repeat (2) @(posedge pclk);
		chk("dead-time mode", 32'h0000_0000, ch0);
		apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0040);
		repeat (2) @(posedge pclk);
		chk("regular between", 32'h0000_0001, ch0);
		apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0060);
		repeat (2) @(posedge pclk);
		chk("balanced mode", 32'h0000_0000, ch0);
		apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0040);
		repeat (4) @(posedge pclk);
		chk("regular again", 32'h0000_0001, ch0);
		fire(32'h0000_0010, 32'h0000_0000, 0);
	endtask
	task automatic t_flags();
		apb(1'b1, opa_pkg::OFS_FLAGCLR, 32'h0000_000F);
		apb(1'b1, opa_pkg::OFS_INTEN, 32'h0000_0F0F);
		fire(32'h0000_0100, 32'h0000_0010, 2);
		apb(1'b0, opa_pkg::OFS_FLAG, 32'h0000_0000);
		chk("flags", 32'h0000_0003, rdv[9:0]);
		chk("requests", 32'h0000_0033, {irq, dma});
		apb(1'b1, opa_pkg::OFS_FLAGCLR, 32'h0000_0000);
		apb(1'b0, opa_pkg::OFS_FLAG, 32'h0000_0000);
		chk("clear zero", 32'h0000_0003, rdv[3:0]);
		apb(1'b1, opa_pkg::OFS_FLAGCLR, 32'h0000_0001);
		apb(1'b0, opa_pkg::OFS_FLAG, 32'h0000_0000);
		chk("clear one", 32'h0000_0002, rdv[3:0]);
		apb(1'b1, opa_pkg::OFS_SET1, 32'h0000_0100);
		apb(1'b1, opa_pkg::OFS_RST1, 32'h0000_0010);
		fire(32'h0000_0100, 32'h0000_0000, 0);
		chk("ch1 high", 32'h0000_0001, ch1);
		chk("ch1 edge pos", 32'h0000_0001, pos1);
		fire(32'h0000_0010, 32'h0000_0000, 0);
		chk("ch1 requests", 32'h0000_000F, irq);
		apb(1'b1, opa_pkg::OFS_FLAGCLR, 32'h0000_000F);
		run <= 1'b0;
		fire(32'h0000_0100, 32'h0000_0010, 2);
		apb(1'b0, opa_pkg::OFS_FLAG, 32'h0000_0000);
		chk("stopped timer", 32'h0000_0000, rdv[3:0]);
		run <= 1'b1;
	endtask
	task automatic t_narrow();
		for (int d = 0; d < 9; d += 8)
		begin
			apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0040 | d);
			for (int g = 1; g < 3; g++)
			begin
				fire(32'h0000_0100, 32'h0000_0010, g);
				chk("pulse width", g, width0);
				chk("narrow pos", 32'h0000_0000, pos0);
			end
		end
	endtask
	task automatic t_policy1();
		int e1;
		apb(1'b1, opa_pkg::OFS_CTRL, 32'h0000_0046);
		fire(32'h0000_0100, 32'h0000_0000, 0);
		e1 = edge_cyc;
		fire(32'h0000_0010, 32'h0000_0000, 0);
		chk("prescaled phase", 32'h0000_0000, (edge_cyc - e1) & 3);
		ev.delay[8] <= 3'h0;
		fire(32'h0000_0100, 32'h0000_0000, 0);
		fire(32'h0000_0110, 32'h0000_0000, 0);
		chk("coincident reset", 32'h0000_0000, ch0);
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_basic();
		t_arbit();
		t_mode();
		t_flags();
		t_narrow();
		t_policy1();
		summarize();
	end
endmodule
